// ==== pls_checker_assertions.sv ====
// Concurrent checks on the ports of the power-loss state selector.
// Assumes one aclk domain with synchronous active-low aresetn.
`include "pls_regs.vh"
module pls_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        power_off,
    input wire logic        stopped,
    input wire logic [2:0]  state_req_r,
    input wire logic        state_req_valid_r,
    input wire logic        decel_active_r
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_valid_needs_loss: assert property (!power_off |=> !state_req_valid_r)
        else $error("state request valid with power present");
    a_no_early_valid: assert property ($rose(power_off) |-> !state_req_valid_r [*8])
        else $error("state request valid before the delay");
    a_decel_needs_loss: assert property (!power_off |=> !decel_active_r)
        else $error("decelerating with power present");
    a_stop_not_fra: assert property (state_req_valid_r && stopped && $past(stopped) && $past(stopped, 2)
        |-> state_req_r != `PLS_ST_FRA)
        else $error("fault reaction requested after stop");
    a_stop_not_qsa: assert property (state_req_valid_r && stopped && $past(stopped) && $past(stopped, 2)
        |-> state_req_r != `PLS_ST_QSA)
        else $error("quick stop requested after stop");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read response late");
endmodule // pls_checker

bind pls_top pls_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .power_off(power_off), .stopped(stopped),
    .state_req_r(state_req_r), .state_req_valid_r(state_req_valid_r), .decel_active_r(decel_active_r));

// ==== pls_motor.sv ====
// Motor and drive model that slows down while deceleration is active.
// Assumes stop_len is held steady during one power loss.
module pls_motor (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       power_off,
    input wire logic       decel_active_r,
    input wire logic       state_req_valid_r,
    input wire logic [2:0] state_req_r,
    input wire logic [2:0] run_state,
    input wire logic [3:0] stop_len,
    output logic           stopped,
    output logic [2:0]     cur_state
);
    logic [3:0] cnt_r;
    always @(posedge aclk) begin
        if (!aresetn || !power_off)
            cnt_r <= 4'h0;
        else if (decel_active_r && cnt_r < stop_len)
            cnt_r <= cnt_r + 4'h1;
    end
    // Speed counts as stopped once enough decelerating cycles have passed.
    assign stopped   = power_off && cnt_r >= stop_len;
    assign cur_state = state_req_valid_r ? state_req_r : run_state;
endmodule // pls_motor

// ==== pls_regs.vh ====
// Register offsets, fields, reset values and timing counts of the power-loss state selector.
// Assumes a 50 MHz aclk and an AXI4-Lite master with 32-bit data.
// What this block does
// - Early table until insulation time, or invalid value
// - Early action 0: hold; Operation enabled stays
// - Action 0 from Quick stop: Switch on disabled
// - Early actions 1,2,3 map to fixed end states
// - Late action 0 select 0: Operation enabled to Ready
// - Late fault cases end in Fault state
// - Late actions 2,3 hold or quick stop
// - Apply quick stop option on Quick Stop command while main power is present
// - Deceleration starts 70 ms after power loss
`ifndef PLS_REGS_VH
`define PLS_REGS_VH

`define PLS_OFF_CTRL        8'h00
`define PLS_OFF_INS_TIME    8'h04
`define PLS_OFF_QS_OPT      8'h08
`define PLS_OFF_SD_OPT      8'h0C
`define PLS_OFF_STATE       8'h10
`define PLS_OFF_IRQ_STAT    8'h14
`define PLS_OFF_IRQ_MASK    8'h18

`define PLS_CTRL_ACT_LSB    0
`define PLS_CTRL_SEL_BIT    4

`define PLS_CTRL_RST        5'h00
`define PLS_INS_RST         16'h07D0
`define PLS_INS_INVALID     16'h07D0

`define PLS_ST_NOT_READY    3'h0
`define PLS_ST_SOD          3'h1
`define PLS_ST_RTSO         3'h2
`define PLS_ST_SWON         3'h3
`define PLS_ST_OPEN         3'h4
`define PLS_ST_QSA          3'h5
`define PLS_ST_FRA          3'h6
`define PLS_ST_FAULT        3'h7

`define PLS_DELAY_MS        70
`define PLS_CLK_MHZ         50
`define PLS_DELAY_CYC       (`PLS_DELAY_MS * 1000 * `PLS_CLK_MHZ)
`define PLS_MS_CYC          (1000 * `PLS_CLK_MHZ)

`define PLS_IRQ_LOSS        0
`define PLS_IRQ_DECEL       1
`define PLS_IRQ_STOP        2
`define PLS_IRQ_LATE        3

`endif

// ==== pls_timer.v ====
// Millisecond timer that runs from the power-loss event.
// Assumes clear is held while main power is present.
`include "pls_regs.vh"
module pls_timer #(
    parameter MS_CYC    = `PLS_MS_CYC,
    parameter DELAY_CYC = `PLS_DELAY_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clear,
    output reg         decel_go_r,
    output reg  [15:0] ms_r
);
    reg [31:0] div_r;
    reg [31:0] dly_r;

    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            div_r      <= 32'h0000_0000;
            dly_r      <= 32'h0000_0000;
            ms_r       <= 16'h0000;
            decel_go_r <= 1'b0;
        end else begin
            if (dly_r >= DELAY_CYC - 1)
                decel_go_r <= 1'b1;
            else
                dly_r <= dly_r + 32'h0000_0001;
            if (div_r >= MS_CYC - 1) begin
                div_r <= 32'h0000_0000;
                if (ms_r != 16'hFFFF)
                    ms_r <= ms_r + 16'h0001;
            end else begin
                div_r <= div_r + 32'h0000_0001;
            end
        end
    end
endmodule // pls_timer

// ==== pls_top.v ====
// Drive-state selector for deceleration and stop after main power loss, with AXI4-Lite registers.
// Assumes power_off, stopped, cur_state and quick_stop_cmd are synchronous to aclk.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`include "pls_regs.vh"
module pls_top #(
    parameter MS_CYC    = `PLS_MS_CYC,
    parameter DELAY_CYC = `PLS_DELAY_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        power_off,
    input  wire        stopped,
    input  wire [2:0]  cur_state,
    input  wire        quick_stop_cmd,
    output reg  [2:0]  state_req_r,
    output reg         state_req_valid_r,
    output reg         decel_active_r,
    output reg  [15:0] decel_method_r,
    output reg         irq_r
);
    reg  [4:0]  ctrl_r;
    reg  [15:0] ins_time_r;
    reg  [15:0] qs_opt_r;
    reg  [15:0] sd_opt_r;
    reg  [3:0]  irq_stat_r;
    reg  [3:0]  irq_mask_r;
    reg  [2:0]  state_at_loss_r;
    reg  [1:0]  act_r;
    reg         sel_r;
    reg         pwr_off_d_r;
    reg         stopped_d_r;
    reg         late_d_r;
    reg         aw_hold_r;
    reg         w_hold_r;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg  [2:0]  dec_state;
    reg  [2:0]  end_state;
    reg  [3:0]  ev;
    reg  [31:0] rd_val;
    reg         rd_ok;
    wire        decel_go;
    wire [15:0] ms;
    wire        late;
    wire        wr_fire;
    wire [31:0] wmask;
    wire [31:0] wv;
    reg  [1:0]  phase_r;
    reg  [1:0]  phase_nxt;
    reg  [15:0] qs_at_loss_r;
    reg  [15:0] sd_at_loss_r;

    // Power-loss phases, readable in the status word.
    localparam [1:0] PH_ON    = 2'd0;
    localparam [1:0] PH_WAIT  = 2'd1;
    localparam [1:0] PH_DECEL = 2'd2;
    localparam [1:0] PH_STOP  = 2'd3;

    pls_timer #(
        .MS_CYC    (MS_CYC),
        .DELAY_CYC (DELAY_CYC)
    ) u_timer (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .clear      (!power_off),
        .decel_go_r (decel_go),
        .ms_r       (ms)
    );

    // Late phase only once the set time has passed and detection is valid.
    assign late = (ins_time_r != `PLS_INS_INVALID) && (ms >= ins_time_r);

    // Selects the state during deceleration and the state after stop.
    always @* begin
        dec_state = state_at_loss_r;
        end_state = `PLS_ST_SOD;
        if (!late) begin
            case (act_r)
                2'd0: begin
                    dec_state = state_at_loss_r;
                    if (state_at_loss_r == `PLS_ST_QSA)
                        end_state = `PLS_ST_SOD;
                    else
                        end_state = state_at_loss_r;
                end
                2'd1: begin
                    dec_state = `PLS_ST_FRA;
                    end_state = `PLS_ST_FAULT;
                end
                2'd2: begin
                    dec_state = state_at_loss_r;
                    end_state = `PLS_ST_SOD;
                end
                default: begin
                    dec_state = `PLS_ST_QSA;
                    end_state = `PLS_ST_SOD;
                end
            endcase
        end else begin
            case (act_r)
                2'd0: begin
                    if (sel_r) begin
                        dec_state = `PLS_ST_FRA;
                        end_state = `PLS_ST_FAULT;
                    end else begin
                        dec_state = state_at_loss_r;
                        if (state_at_loss_r == `PLS_ST_QSA)
                            end_state = `PLS_ST_SOD;
                        else if (state_at_loss_r == `PLS_ST_OPEN)
                            end_state = `PLS_ST_RTSO;
                        else
                            end_state = state_at_loss_r;
                    end
                end
                2'd1: begin
                    dec_state = `PLS_ST_FRA;
                    end_state = `PLS_ST_FAULT;
                end
                2'd2: begin
                    if (sel_r && sd_at_loss_r != 16'h0000) begin
                        dec_state = `PLS_ST_FRA;
                        end_state = `PLS_ST_FAULT;
                    end else begin
                        dec_state = state_at_loss_r;
                        end_state = `PLS_ST_SOD;
                    end
                end
                default: begin
                    if (sel_r && qs_at_loss_r != 16'h0000) begin
                        dec_state = `PLS_ST_FRA;
                        end_state = `PLS_ST_FAULT;
                    end else begin
                        dec_state = `PLS_ST_QSA;
                        end_state = `PLS_ST_SOD;
                    end
                end
            endcase
        end
    end

    // Event sources for the sticky status bits.
    always @* begin
        ev = 4'h0;
        ev[`PLS_IRQ_LOSS]  = power_off && !pwr_off_d_r;
        ev[`PLS_IRQ_DECEL] = decel_go && !decel_active_r && power_off && !stopped;
        ev[`PLS_IRQ_STOP]  = power_off && decel_go && stopped && !stopped_d_r;
        ev[`PLS_IRQ_LATE]  = power_off && late && !late_d_r;
    end

    // Drive-state outputs.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_at_loss_r   <= `PLS_ST_NOT_READY;
            act_r             <= 2'd0;
            sel_r             <= 1'b0;
            qs_at_loss_r      <= 16'h0000;
            sd_at_loss_r      <= 16'h0000;
            pwr_off_d_r       <= 1'b0;
            stopped_d_r       <= 1'b0;
            late_d_r          <= 1'b0;
            state_req_r       <= `PLS_ST_NOT_READY;
            state_req_valid_r <= 1'b0;
            decel_active_r    <= 1'b0;
            decel_method_r    <= 16'h0000;
        end else begin
            pwr_off_d_r <= power_off;
            stopped_d_r <= stopped;
            // Cleared while power is present, so every power loss can report entering the late phase.
            late_d_r    <= power_off && late;
            if (power_off && !pwr_off_d_r) begin
                state_at_loss_r <= cur_state;
                act_r           <= ctrl_r[`PLS_CTRL_ACT_LSB +: 2];
                sel_r           <= ctrl_r[`PLS_CTRL_SEL_BIT];
                qs_at_loss_r    <= qs_opt_r;
                sd_at_loss_r    <= sd_opt_r;
            end
            if (!power_off) begin
                state_req_valid_r <= 1'b0;
                decel_active_r    <= 1'b0;
                if (quick_stop_cmd)
                    decel_method_r <= qs_opt_r;
            end else if (decel_go) begin
                state_req_valid_r <= 1'b1;
                decel_active_r    <= !stopped;
                state_req_r       <= stopped ? end_state : dec_state;
                decel_method_r    <= (act_r == 2'd3) ? qs_at_loss_r : sd_at_loss_r;
            end
        end
    end

    // Power-loss phase: waiting out the delay, decelerating, stopped.
    always @* begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_ON: begin
                if (power_off)
                    phase_nxt = PH_WAIT;
            end
            PH_WAIT: begin
                if (decel_go)
                    phase_nxt = stopped ? PH_STOP : PH_DECEL;
            end
            PH_DECEL: begin
                if (stopped)
                    phase_nxt = PH_STOP;
            end
            PH_STOP: begin
                phase_nxt = PH_STOP;
            end
            default: begin
                phase_nxt = PH_ON;
            end
        endcase
        if (!power_off)
            phase_nxt = PH_ON;
    end

    always @(posedge aclk) begin
        if (!aresetn)
            phase_r <= PH_ON;
        else
            phase_r <= phase_nxt;
    end

    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mask
            assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
        end
    endgenerate
    assign wv = w_data_r & wmask;

    // Read data mux.
    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `PLS_OFF_CTRL:     rd_val = {27'h000_0000, ctrl_r};
            `PLS_OFF_INS_TIME: rd_val = {16'h0000, ins_time_r};
            `PLS_OFF_QS_OPT:   rd_val = {16'h0000, qs_opt_r};
            `PLS_OFF_SD_OPT:   rd_val = {16'h0000, sd_opt_r};
            `PLS_OFF_STATE:    rd_val = {ms, 6'h00, phase_r, late, decel_active_r, state_req_valid_r, power_off,
                                         1'b0, state_req_r};
            `PLS_OFF_IRQ_STAT: rd_val = {28'h000_0000, irq_stat_r};
            `PLS_OFF_IRQ_MASK: rd_val = {28'h000_0000, irq_mask_r};
            default:           rd_ok = 1'b0;
        endcase
    end

    // AXI4-Lite slave and register file.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            ctrl_r        <= `PLS_CTRL_RST;
            ins_time_r    <= `PLS_INS_RST;
            qs_opt_r      <= 16'h0000;
            sd_opt_r      <= 16'h0000;
            irq_stat_r    <= 4'h0;
            irq_mask_r    <= 4'h0;
            irq_r         <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_hold_r && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_hold_r     <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_hold_r     <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr_r)
                    `PLS_OFF_CTRL:     ctrl_r <= (ctrl_r & ~wmask[4:0]) | wv[4:0];
                    `PLS_OFF_INS_TIME: ins_time_r <= (ins_time_r & ~wmask[15:0]) | wv[15:0];
                    `PLS_OFF_QS_OPT:   qs_opt_r <= (qs_opt_r & ~wmask[15:0]) | wv[15:0];
                    `PLS_OFF_SD_OPT:   sd_opt_r <= (sd_opt_r & ~wmask[15:0]) | wv[15:0];
                    `PLS_OFF_IRQ_MASK: irq_mask_r <= (irq_mask_r & ~wmask[3:0]) | wv[3:0];
                    `PLS_OFF_IRQ_STAT: ;
                    `PLS_OFF_STATE:    ;
                    default:           s_axi_bresp <= 2'b10;
                endcase
            end
            // Set wins over a write-one clear in the same cycle.
            if (wr_fire && aw_addr_r == `PLS_OFF_IRQ_STAT)
                irq_stat_r <= (irq_stat_r & ~wv[3:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read channel.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
            end
        end
    end
endmodule // pls_top

// ==== power_loss_drive_state_select_test.sv ====
// Self-checking bench for the power-loss state selector over AXI4-Lite.
// Assumes shortened timing parameters and the motor model of pls_motor.sv.
`include "pls_regs.vh"
module power_loss_drive_state_select_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DC = 20;
    localparam logic [2:0] OE = `PLS_ST_OPEN, QS = `PLS_ST_QSA, SD = `PLS_ST_SOD, SW = `PLS_ST_SWON;
    localparam logic [2:0] RT = `PLS_ST_RTSO, FR = `PLS_ST_FRA, FT = `PLS_ST_FAULT;
    localparam logic [15:0] INV = `PLS_INS_INVALID;
    logic        aclk = 0, aresetn = 0, power_off = 0, quick_stop_cmd = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [3:0]  s_axi_wstrb = 4'hF, stop_len = 4'h3;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        stopped, state_req_valid_r, decel_active_r, irq_r;
    logic [2:0]  cur_state, state_req_r, run_state = OE;
    logic [15:0] decel_method_r;
    int          n_mismatch = 0, n_compared = 0;
    always #10 aclk = ~aclk;
    pls_top #(.MS_CYC(10), .DELAY_CYC(DC)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_off, .stopped, .cur_state, .quick_stop_cmd,
        .state_req_r, .state_req_valid_r, .decel_active_r, .decel_method_r, .irq_r);
    pls_motor u_motor (.aclk, .aresetn, .power_off, .decel_active_r, .state_req_valid_r, .state_req_r,
        .run_state, .stop_len, .stopped, .cur_state);
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        check(s_axi_bresp, e);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    // One power loss: settings, delay, state while slowing, state after stop.
    task automatic go(input logic [1:0] act, input logic sel, input logic [15:0] ins, input logic [15:0] opt,
                      input logic [2:0] cur, input logic [2:0] d, input logic [2:0] s, input logic late);
        int n;
        wr(`PLS_OFF_CTRL, {27'h0, sel, 2'b00, act}, 0);
        wr(`PLS_OFF_INS_TIME, {16'h0, ins}, 0);
        wr(`PLS_OFF_QS_OPT, {16'h0, opt}, 0);
        wr(`PLS_OFF_SD_OPT, {16'h0, opt}, 0);
        run_state <= cur;
        stop_len <= stop_len ^ 4'hB;
        @(posedge aclk) power_off <= 1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!state_req_valid_r && n < 100);
        check(n >= DC && n <= DC + 4, 1);
        @(posedge aclk);
        check(state_req_r, d);
        check(decel_active_r, 1);
        check(decel_method_r, opt);
        n = 0;
        while (!stopped && n < 50) begin
            @(posedge aclk);
            n++;
        end
        repeat (3) @(posedge aclk);
        check(state_req_r, s);
        rd(`PLS_OFF_STATE);
        check(rv[7], late);
        check(rv[9:8], 2'd3);
        power_off <= 0;
        repeat (3) @(posedge aclk);
        $display("case action %0d select %0d done", act, sel);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 8; i++) begin
            rd(i * 4);
            check(rv, i == 1 ? INV : 0);
            check(rr, i == 7 ? 2 : 0);
        end
        wr(8'h1C, 32'h0000_0000, 2);
        wr(`PLS_OFF_QS_OPT, 32'h0000_1234, 0);
        @(posedge aclk) quick_stop_cmd <= 1;
        @(posedge aclk) quick_stop_cmd <= 0;
        repeat (2) @(posedge aclk);
        check(decel_method_r, 16'h1234);
        $display("registers done");
        go(0, 1, INV, 0, OE, OE, OE, 0);
        go(0, 0, INV, 0, QS, QS, SD, 0);
        go(1, 0, INV, 0, OE, FR, FT, 0);
        go(2, 1, INV, 5, SW, SW, SD, 0);
        go(3, 1, INV, 5, OE, QS, SD, 0);
        go(0, 1, 16'h03E8, 0, OE, OE, OE, 0);
        go(0, 0, 0, 0, OE, OE, RT, 1);
        go(0, 0, 0, 0, QS, QS, SD, 1);
        go(0, 1, 0, 0, OE, FR, FT, 1);
        go(1, 0, 0, 0, OE, FR, FT, 1);
        go(2, 1, 0, 5, OE, FR, FT, 1);
        go(3, 1, 0, 5, OE, FR, FT, 1);
        go(2, 1, 0, 0, OE, OE, SD, 1);
        go(2, 0, 0, 5, OE, OE, SD, 1);
        go(3, 0, 0, 5, OE, QS, SD, 1);
        go(3, 1, 0, 0, OE, QS, SD, 1);
        rd(`PLS_OFF_IRQ_STAT);
        check(rv[3:0], 4'hF);
        check(irq_r, 0);
        wr(`PLS_OFF_IRQ_MASK, 32'h0000_000F, 0);
        repeat (2) @(posedge aclk);
        check(irq_r, 1);
        wr(`PLS_OFF_IRQ_STAT, 32'h0000_000F, 0);
        repeat (2) @(posedge aclk);
        check(irq_r, 0);
        rd(`PLS_OFF_IRQ_STAT);
        check(rv[3:0], 4'h0);
        $display("interrupts done");
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        end_of_test;
    end
endmodule // power_loss_drive_state_select_test
